// >>> rtl/io_space_regs.vh
// Address map, field masks and reset values of the lower I/O register space
`ifndef IO_SPACE_REGS_VH
`define IO_SPACE_REGS_VH
// ==========================================================
// Address windows
`define IO_DATA_OFFSET 9'h020
`define IO_LAST_ADDR 6'h3F
`define IO_BIT_LAST_ADDR 6'h1F
`define EXT_IO_FIRST 9'h060
`define EXT_IO_LAST 9'h1FF
// ==========================================================
// Register offsets (raw I/O addresses)
`define GPIO_PORT_B_INPUT_PINS 6'h03
`define GPIO_PORT_B_DIRECTION 6'h04
`define GPIO_PORT_B_OUTPUT 6'h05
`define GPIO_PORT_C_INPUT_PINS 6'h06
`define GPIO_PORT_C_DIRECTION 6'h07
`define GPIO_PORT_C_OUTPUT 6'h08
`define GPIO_PORT_D_INPUT_PINS 6'h09
`define GPIO_PORT_D_DIRECTION 6'h0A
`define GPIO_PORT_D_OUTPUT 6'h0B
`define TIMER0_EVENT_FLAGS 6'h15
`define TIMER1_EVENT_FLAGS 6'h16
`define GENERAL_SCRATCH_0 6'h1E
`define EEPROM_CONTROL 6'h1F
`define EEPROM_DATA 6'h20
`define EEPROM_ADDRESS_HIGH 6'h22
`define GENERAL_TIMER_CONTROL 6'h23
`define TIMER0_CONTROL_A 6'h24
`define TIMER0_CONTROL_B 6'h25
`define TIMER0_COUNT_VALUE 6'h26
`define TIMER0_COMPARE_A 6'h27
`define TIMER0_COMPARE_B 6'h28
`define PLL_CONTROL_STATUS 6'h29
`define GENERAL_SCRATCH_1 6'h2A
`define GENERAL_SCRATCH_2 6'h2B
`define SERIAL_PERIPHERAL_CONTROL 6'h2C
// ==========================================================
// Implemented-bit masks and register reset value
`define PORT_C_MASK 8'hF7
`define TIMER0_FLAG_MASK 8'h07
`define TIMER1_FLAG_MASK 8'h2F
`define EEPROM_CONTROL_MASK 8'h3F
`define EEPROM_ADDRESS_HIGH_MASK 8'h03
`define GENERAL_TIMER_MASK 8'h83
`define TIMER0_CONTROL_A_MASK 8'hF3
`define TIMER0_CONTROL_B_MASK 8'hCF
`define PLL_CONTROL_MASK 8'h1F
`define REG_RESET 8'h00
`endif

// >>> rtl/io_bit_op.v
// Single-bit set, clear and test helper for bit-accessible I/O registers
`timescale 1ns/1ps
module io_bit_op (
  input wire [7:0] current,
  input wire [2:0] bit_sel,
  input wire set_bit,
  output reg [7:0] modified,
  output reg bit_value
);
  // ==========================================================
  // Read-modify-write of the whole byte
  always @* begin
    modified = current;
    modified[bit_sel] = set_bit;
    bit_value = current[bit_sel];
  end
endmodule // io_bit_op

// >>> rtl/io_space_register_decode.v
// Lower I/O space decoder with register bank, bit ops and data-space aliasing
// Behaviour
// RULE_01 - Software writes zero into reserved bits
// RULE_02 - Reserved bit reads are undefined to software
// RULE_03 - Software never writes reserved I/O addresses
// RULE_04 - Addresses 00 to 1F support bit set/clear
// RULE_05 - Bit tests read any bit below 20
// RULE_06 - Some flags clear on writing one
// RULE_07 - Bit set/clear rewrites whole register, clearing flags
// RULE_08 - Bit set/clear act only below 20
// RULE_09 - I/O transfers use raw addresses 00-3F
// RULE_10 - Data-space address is I/O address plus 20
// RULE_11 - I/O opcode reaches exactly 64 locations
// RULE_12 - Extended 60-1FF reachable by load/store only
// RULE_13 - Reserved addresses ignore writes, read zero
`timescale 1ns/1ps
`include "io_space_regs.vh"
module io_space_register_decode (
  input wire clk,
  input wire rst,
  // Core I/O transfers and bit operations
  input wire io_rd,
  input wire io_wr,
  input wire [5:0] io_addr,
  input wire [7:0] io_wdata,
  input wire set_io_bit_instr,
  input wire clear_io_bit_instr,
  input wire bit_test_instr,
  input wire [2:0] bit_sel,
  // Data-space loads and stores
  input wire ds_rd,
  input wire ds_wr,
  input wire [8:0] ds_addr,
  input wire [7:0] ds_wdata,
  // Pin levels, hardware flag events and extended read data
  input wire [7:0] port_b_pins,
  input wire [7:0] port_c_pins,
  input wire [7:0] port_d_pins,
  input wire [7:0] timer0_flag_set,
  input wire [7:0] timer1_flag_set,
  input wire [7:0] ext_rdata,
  // Read data and extended forwarding
  output reg [7:0] rdata,
  output reg bit_test_value,
  output reg ext_sel,
  output reg ext_wr,
  output reg [8:0] ext_addr,
  output reg [7:0] ext_wdata,
  // Register contents to the peripherals
  output wire [7:0] port_b_direction,
  output wire [7:0] port_b_output,
  output wire [7:0] port_c_direction,
  output wire [7:0] port_c_output,
  output wire [7:0] port_d_direction,
  output wire [7:0] port_d_output,
  output wire [7:0] timer0_flags,
  output wire [7:0] timer1_flags,
  output wire [7:0] eeprom_control,
  output wire [7:0] eeprom_data,
  output wire [7:0] eeprom_address_high,
  output wire [7:0] general_timer_control,
  output wire [7:0] timer0_control_a,
  output wire [7:0] timer0_control_b,
  output wire [7:0] timer0_count_value,
  output wire [7:0] timer0_compare_a,
  output wire [7:0] timer0_compare_b,
  output wire [7:0] pll_control_status,
  output wire [7:0] serial_peripheral_control
);
  localparam NREG = 64;

  // ==========================================================
  // Decode helpers
  function [7:0] reg_mask;
    input [5:0] a;
    begin
      case (a)
        `GPIO_PORT_B_DIRECTION,
        `GPIO_PORT_B_OUTPUT,
        `GPIO_PORT_D_DIRECTION,
        `GPIO_PORT_D_OUTPUT,
        `GENERAL_SCRATCH_0,
        `EEPROM_DATA,
        `TIMER0_COUNT_VALUE,
        `TIMER0_COMPARE_A,
        `TIMER0_COMPARE_B,
        `GENERAL_SCRATCH_1,
        `GENERAL_SCRATCH_2,
        `SERIAL_PERIPHERAL_CONTROL: reg_mask = 8'hFF;
        // Unused bits are tied low so reads return zero
        `GPIO_PORT_C_DIRECTION,
        `GPIO_PORT_C_OUTPUT: reg_mask = `PORT_C_MASK;
        `TIMER0_EVENT_FLAGS: reg_mask = `TIMER0_FLAG_MASK;
        `TIMER1_EVENT_FLAGS: reg_mask = `TIMER1_FLAG_MASK;
        `EEPROM_CONTROL: reg_mask = `EEPROM_CONTROL_MASK;
        `EEPROM_ADDRESS_HIGH: reg_mask = `EEPROM_ADDRESS_HIGH_MASK;
        `GENERAL_TIMER_CONTROL: reg_mask = `GENERAL_TIMER_MASK;
        `TIMER0_CONTROL_A: reg_mask = `TIMER0_CONTROL_A_MASK;
        `TIMER0_CONTROL_B: reg_mask = `TIMER0_CONTROL_B_MASK;
        `PLL_CONTROL_STATUS: reg_mask = `PLL_CONTROL_MASK;
        default: reg_mask = 8'h00;
      endcase
    end
  endfunction

  function is_w1c;
    input [5:0] a;
    begin
      case (a)
        `TIMER0_EVENT_FLAGS,
        `TIMER1_EVENT_FLAGS: is_w1c = 1'b1;
        default: is_w1c = 1'b0;
      endcase
    end
  endfunction

  // Only the lowest 32 locations take bit ops and tests
  function is_bit_addr;
    input [5:0] a;
    begin
      is_bit_addr = (a <= `IO_BIT_LAST_ADDR);
    end
  endfunction

  function [7:0] event_bits;
    input [5:0] a;
    input [7:0] t0;
    input [7:0] t1;
    begin
      case (a)
        `TIMER0_EVENT_FLAGS: event_bits = t0;
        `TIMER1_EVENT_FLAGS: event_bits = t1;
        default: event_bits = 8'h00;
      endcase
    end
  endfunction

  function [7:0] pin_value;
    input [5:0] a;
    input [7:0] pb;
    input [7:0] pc;
    input [7:0] pd;
    begin
      case (a)
        `GPIO_PORT_B_INPUT_PINS: pin_value = pb;
        `GPIO_PORT_C_INPUT_PINS: pin_value = pc & `PORT_C_MASK;
        `GPIO_PORT_D_INPUT_PINS: pin_value = pd;
        default: pin_value = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // Address resolution for both access paths
  reg [7:0] regs [0:NREG-1];
  reg [5:0] acc_addr;
  reg acc_io;
  reg acc_wr;
  reg acc_rd;
  reg [7:0] acc_wdata;
  reg ds_in_io;
  reg ds_ext;
  reg [8:0] ds_rel;
  reg bit_op;
  wire [7:0] cur_val;
  wire [7:0] bit_mod;
  wire bit_val;

  // ==========================================================
  // Data-space window
  always @* begin
    ds_rel = ds_addr - `IO_DATA_OFFSET;
    // Data address = I/O address + 20, 64 locations only
    ds_in_io = (ds_addr >= `IO_DATA_OFFSET) &&
      (ds_rel <= {3'b000, `IO_LAST_ADDR}); // see RULE_10 see RULE_11
    // Extended space only via load/store path
    ds_ext = (ds_addr >= `EXT_IO_FIRST) && (ds_addr <= `EXT_IO_LAST); // see RULE_12
  end

  // ==========================================================
  // Request arbitration, I/O path first
  always @* begin
    // Bit ops refuse addresses above 1F
    bit_op = (set_io_bit_instr | clear_io_bit_instr) &&
      is_bit_addr(io_addr); // see RULE_04 see RULE_08
    acc_io = io_rd | io_wr | bit_op | bit_test_instr; // see RULE_09
    acc_addr = acc_io ? io_addr : ds_rel[5:0];
    acc_wr = io_wr | bit_op | (~acc_io & ds_wr & ds_in_io);
    acc_rd = io_rd | (~acc_io & ds_rd & ds_in_io);
    acc_wdata = bit_op ? bit_mod : (io_wr ? io_wdata : ds_wdata);
  end

  // ==========================================================
  // Addressed byte and its read-modify-write
  // Pin levels are ORed in here; pin slots hold no storage
  assign cur_val = (regs[acc_addr] & reg_mask(acc_addr)) |
    pin_value(acc_addr, port_b_pins, port_c_pins, port_d_pins);
  io_bit_op u_bit_op (
    .current(cur_val),
    .bit_sel(bit_sel),
    .set_bit(set_io_bit_instr),
    .modified(bit_mod),
    .bit_value(bit_val)
  );

  // ==========================================================
  // Register bank update
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      wire [31:0] gi = g;
      wire [5:0] ga = gi[5:0];
      wire hit = acc_wr && (acc_addr == ga);
      wire [7:0] msk = reg_mask(ga);
      // Hardware event pulses, only the two flag registers have any
      wire [7:0] evt = event_bits(ga, timer0_flag_set, timer1_flag_set);
      reg [7:0] next_val;
      always @* begin
        next_val = regs[g];
        if (hit) begin
          if (is_w1c(ga)) begin
            // Bit op writes back ones read as set
            next_val = regs[g] & ~acc_wdata; // see RULE_06 see RULE_07
          end else begin
            next_val = acc_wdata; // see RULE_04
          end
        end
        // Hardware set beats software clear
        next_val = (next_val | evt) & msk; // see RULE_13 see RULE_02
      end
      always @(posedge clk) begin
        if (rst) begin
          regs[g] <= `REG_RESET;
        end else begin
          regs[g] <= next_val; // see RULE_13
        end
      end
    end
  endgenerate

  // ==========================================================
  // Extended space forwarding
  always @(posedge clk) begin
    if (rst) begin
      ext_sel <= 1'b0;
      ext_wr <= 1'b0;
      ext_addr <= 9'h000;
      ext_wdata <= 8'h00;
    end else begin
      // An I/O read, write, test or bit op below 20 in the same cycle drops the data-space access
      ext_sel <= ~acc_io & ds_ext & (ds_rd | ds_wr); // see RULE_12
      ext_wr <= ~acc_io & ds_ext & ds_wr;
      ext_addr <= ds_addr;
      ext_wdata <= ds_wdata;
    end
  end

  // ==========================================================
  // Bit test result, held until the next in-range test
  always @(posedge clk) begin
    if (rst) begin
      bit_test_value <= 1'b0;
    end else if (bit_test_instr && is_bit_addr(io_addr)) begin
      bit_test_value <= bit_val; // see RULE_05
    end
  end

  // ==========================================================
  // Read data
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (acc_rd) begin
      rdata <= cur_val; // see RULE_13
    end else if (~acc_io & ds_rd & ds_ext) begin
      rdata <= ext_rdata; // see RULE_12
    end else if (acc_io | ds_rd) begin
      // I/O writes, tests and bit ops below 20 leave zero; data-space writes keep the last byte
      rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Port register outputs
  assign port_b_direction = regs[`GPIO_PORT_B_DIRECTION];
  assign port_b_output = regs[`GPIO_PORT_B_OUTPUT];
  assign port_c_direction = regs[`GPIO_PORT_C_DIRECTION];
  assign port_c_output = regs[`GPIO_PORT_C_OUTPUT];
  assign port_d_direction = regs[`GPIO_PORT_D_DIRECTION];
  assign port_d_output = regs[`GPIO_PORT_D_OUTPUT];

  // ==========================================================
  // Flag, memory and peripheral control outputs
  assign timer0_flags = regs[`TIMER0_EVENT_FLAGS];
  assign timer1_flags = regs[`TIMER1_EVENT_FLAGS];
  assign eeprom_control = regs[`EEPROM_CONTROL];
  assign eeprom_data = regs[`EEPROM_DATA];
  assign eeprom_address_high = regs[`EEPROM_ADDRESS_HIGH];
  assign general_timer_control = regs[`GENERAL_TIMER_CONTROL];
  assign timer0_control_a = regs[`TIMER0_CONTROL_A];
  assign timer0_control_b = regs[`TIMER0_CONTROL_B];
  assign timer0_count_value = regs[`TIMER0_COUNT_VALUE];
  assign timer0_compare_a = regs[`TIMER0_COMPARE_A];
  assign timer0_compare_b = regs[`TIMER0_COMPARE_B];
  assign pll_control_status = regs[`PLL_CONTROL_STATUS];
  assign serial_peripheral_control = regs[`SERIAL_PERIPHERAL_CONTROL];
endmodule // io_space_register_decode

// >>> testbench/io_space_register_decode_chk.sv
// Port-level checks of the lower I/O space decoder
`timescale 1ns/1ps
module io_space_register_decode_chk (
  input wire clk,
  input wire rst,
  input wire io_rd,
  input wire io_wr,
  input wire [5:0] io_addr,
  input wire [7:0] io_wdata,
  input wire set_io_bit_instr,
  input wire clear_io_bit_instr,
  input wire bit_test_instr,
  input wire [2:0] bit_sel,
  input wire ds_rd,
  input wire [8:0] ds_addr,
  input wire [7:0] timer0_flag_set,
  input wire [7:0] rdata,
  input wire bit_test_value,
  input wire ext_sel,
  input wire [8:0] ext_addr,
  input wire [7:0] port_b_direction,
  input wire [7:0] timer0_flags
);
  // I/O reads, writes, tests and bit ops below 20 win over data-space access
  wire io_any = io_rd | io_wr | set_io_bit_instr | clear_io_bit_instr | bit_test_instr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_io_write;
    io_wr && io_addr == 6'h04 |=> port_b_direction == $past(io_wdata);
  endproperty
  a_io_write: assert property (p_io_write) else $error("I/O write lost");
  property p_alias_read;
    ds_rd && !io_any && ds_addr == 9'h024 |=> rdata == $past(port_b_direction);
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("alias read wrong");
  property p_bit_set;
    set_io_bit_instr && io_addr == 6'h04
      |=> port_b_direction == ($past(port_b_direction) | (8'h01 << $past(bit_sel)));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");
  property p_bit_clear;
    clear_io_bit_instr && io_addr == 6'h04
      |=> port_b_direction == ($past(port_b_direction) & ~(8'h01 << $past(bit_sel)));
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");
  property p_bitop_high;
    (set_io_bit_instr || clear_io_bit_instr) && io_addr > 6'h1F |=> $stable(port_b_direction);
  endproperty
  a_bitop_high: assert property (p_bitop_high) else $error("high bit op acted");
  property p_bit_test;
    bit_test_instr && io_addr == 6'h04
      |=> bit_test_value == |($past(port_b_direction) & (8'h01 << $past(bit_sel)));
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("bit test wrong");
  property p_w1c;
    io_wr && io_addr == 6'h15 && timer0_flag_set == 8'h00
      |=> timer0_flags == ($past(timer0_flags) & ~$past(io_wdata));
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag clear wrong");
  property p_rmw_w1c;
    set_io_bit_instr && io_addr == 6'h15 && timer0_flag_set == 8'h00 |=> timer0_flags == 8'h00;
  endproperty
  a_rmw_w1c: assert property (p_rmw_w1c) else $error("bit op kept a flag");
  property p_ext_select;
    ds_rd && !io_any && ds_addr >= 9'h060 |=> ext_sel && ext_addr == $past(ds_addr);
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("extended select wrong");
endmodule // io_space_register_decode_chk
bind io_space_register_decode io_space_register_decode_chk chk_i (.clk(clk), .rst(rst),
  .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
  .set_io_bit_instr(set_io_bit_instr), .clear_io_bit_instr(clear_io_bit_instr),
  .bit_test_instr(bit_test_instr), .bit_sel(bit_sel), .ds_rd(ds_rd), .ds_addr(ds_addr),
  .timer0_flag_set(timer0_flag_set), .rdata(rdata), .bit_test_value(bit_test_value),
  .ext_sel(ext_sel), .ext_addr(ext_addr), .port_b_direction(port_b_direction),
  .timer0_flags(timer0_flags));

// >>> testbench/ext_io_model.sv
// Extended I/O space behind the decoder
`timescale 1ns/1ps
module ext_io_model (
  input wire clk,
  input wire ext_sel,
  input wire ext_wr,
  input wire [8:0] ext_addr,
  input wire [7:0] ext_wdata,
  input wire ds_rd,
  input wire [8:0] ds_addr,
  output wire [7:0] ext_rdata
);
  reg [7:0] mem [0:511];
  always @(posedge clk) begin
    if (ext_sel && ext_wr) begin
      mem[ext_addr] <= ext_wdata;
    end
  end
  // Idle bus toggles, so a stale byte never passes for data
  assign ext_rdata = (ds_rd && ds_addr >= 9'h060) ? mem[ds_addr] : {4{clk, ~clk}};
endmodule // ext_io_model

// >>> testbench/tb_io_space_register_decode.sv
// Directed bench for the lower I/O space decoder
`timescale 1ns/1ps
module tb_io_space_register_decode;
  reg clk, rst, io_rd, io_wr, set_io_bit_instr, clear_io_bit_instr, bit_test_instr, ds_rd, ds_wr;
  reg [5:0] io_addr;
  reg [2:0] bit_sel;
  reg [8:0] ds_addr;
  reg [7:0] io_wdata, ds_wdata, timer0_flag_set;
  wire [7:0] ext_rdata, rdata, ext_wdata, pbd, pbo, pcd, t0f, t0ca, eec;
  wire bit_test_value, ext_sel, ext_wr;
  wire [8:0] ext_addr;
  integer bad_count, num_checks, cycles;
  io_space_register_decode dut (.clk(clk), .rst(rst), .io_rd(io_rd), .io_wr(io_wr),
    .io_addr(io_addr), .io_wdata(io_wdata), .set_io_bit_instr(set_io_bit_instr),
    .clear_io_bit_instr(clear_io_bit_instr), .bit_test_instr(bit_test_instr),
    .bit_sel(bit_sel), .ds_rd(ds_rd), .ds_wr(ds_wr), .ds_addr(ds_addr), .ds_wdata(ds_wdata),
    .port_b_pins(8'hC3), .port_c_pins(8'hFF), .port_d_pins(8'h3C),
    .timer0_flag_set(timer0_flag_set), .timer1_flag_set(8'h00), .ext_rdata(ext_rdata),
    .rdata(rdata), .bit_test_value(bit_test_value), .ext_sel(ext_sel), .ext_wr(ext_wr),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .port_b_direction(pbd), .port_b_output(pbo),
    .port_c_direction(pcd), .port_c_output(), .port_d_direction(), .port_d_output(),
    .timer0_flags(t0f), .timer1_flags(), .eeprom_control(eec), .eeprom_data(),
    .eeprom_address_high(), .general_timer_control(), .timer0_control_a(t0ca),
    .timer0_control_b(), .timer0_count_value(), .timer0_compare_a(), .timer0_compare_b(),
    .pll_control_status(), .serial_peripheral_control());
  ext_io_model far_end (.clk(clk), .ext_sel(ext_sel), .ext_wr(ext_wr), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ds_rd(ds_rd), .ds_addr(ds_addr), .ext_rdata(ext_rdata));
  // ==========================================================
  // Access tasks
  // Kinds: 0 io write, 1 io read, 2 ds write, 3 ds read, 4 set, 5 clear, 6 test
  task op(input [2:0] k, input [8:0] a, input [7:0] d);
    begin
      @(posedge clk);
      io_addr <= a[5:0];
      ds_addr <= a;
      io_wdata <= d;
      ds_wdata <= d;
      bit_sel <= d[2:0];
      {io_wr, io_rd, ds_wr, ds_rd, set_io_bit_instr, clear_io_bit_instr,
        bit_test_instr} <= 7'h40 >> k;
      @(posedge clk);
      {io_wr, io_rd, ds_wr, ds_rd, set_io_bit_instr, clear_io_bit_instr,
        bit_test_instr} <= 7'h00;
      #1;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Guards against a hung handshake; the sequence needs under 200 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  // ==========================================================
  // Test sequence
  initial begin
    {rst, io_rd, io_wr, set_io_bit_instr, clear_io_bit_instr, bit_test_instr, ds_rd,
      ds_wr} = 8'h80;
    {io_addr, bit_sel, ds_addr, io_wdata, ds_wdata, timer0_flag_set} = 0;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    op(0, 9'h004, 8'hA5);
    chk(pbd, 8'hA5);
    op(1, 9'h004, 8'h00);
    chk(rdata, 8'hA5);
    op(3, 9'h024, 8'h00);
    chk(rdata, 8'hA5);
    op(2, 9'h025, 8'h5A);
    chk(pbo, 8'h5A);
    // Top implemented slot through the data-space alias
    op(0, 9'h02C, 8'h81);
    op(3, 9'h04C, 8'h00);
    chk(rdata, 8'h81);
    op(4, 9'h004, 8'h01);
    chk(pbd, 8'hA7);
    op(5, 9'h004, 8'h00);
    chk(pbd, 8'hA6);
    op(4, 9'h01F, 8'h05);
    chk(eec, 8'h20);
    op(6, 9'h004, 8'h02);
    chk({7'h00, bit_test_value}, 8'h01);
    op(6, 9'h004, 8'h03);
    chk({7'h00, bit_test_value}, 8'h00);
    op(4, 9'h024, 8'h00);
    chk(t0ca, 8'h00);
    @(posedge clk) timer0_flag_set <= 8'hFF;
    @(posedge clk) timer0_flag_set <= 8'h00;
    #1 chk(t0f, 8'h07);
    op(0, 9'h015, 8'h02);
    chk(t0f, 8'h05);
    op(4, 9'h015, 8'h01);
    chk(t0f, 8'h00);
    // Pins read back while their slots ignore writes
    op(0, 9'h009, 8'h00);
    op(1, 9'h009, 8'h00);
    chk(rdata, 8'h3C);
    // Reserved slots are only read, never written
    op(1, 9'h001, 8'h00);
    chk(rdata, 8'h00);
    op(0, 9'h007, 8'hF7);
    chk(pcd, 8'hF7);
    op(1, 9'h006, 8'h00);
    chk(rdata, 8'hF7);
    op(2, 9'h061, 8'h96);
    op(3, 9'h061, 8'h00);
    chk(rdata, 8'h96);
    end_sim;
  end
endmodule // tb_io_space_register_decode
